//--- src/sar_adc_parallel_control.sv
// Conversion control, result latch and parallel port of the sampling converter
`timescale 1ns/1ps
`default_nettype none
module sar_adc_parallel_control #(
    parameter int RES_BITS = sar_ctrl_pkg::RES_BITS,
    parameter int DEPTH    = sar_ctrl_pkg::FIFO_DEPTH
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                cs_n,
    input  wire logic                rd_n,
    input  wire logic                convert_start_n,
    input  wire logic                power_down_n,
    input  wire logic                comp_high,
    output logic                     sample_hold,
    output logic     [RES_BITS-1:0]  dac_code,
    output logic                     busy_n,
    output logic     [RES_BITS-1:0]  result_out,
    output logic     [RES_BITS-1:0]  result_oe,
    output logic                     nap,
    output logic                     sleep,
    output logic     [RES_BITS-1:0]  stream_data,
    output logic                     stream_valid,
    input  wire logic                stream_ready,
    output logic                     overrun
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        sar_ctrl_pkg::pins_s       meta;
        sar_ctrl_pkg::pins_s       sync;
        logic                      conv_prev;
        logic                      pd_prev;
        sar_ctrl_pkg::conv_state_e state;
        sar_ctrl_pkg::power_mode_e pmode;
        logic [RES_BITS-1:0]       approx_register;
        logic [RES_BITS-1:0]       latch;
        logic [3:0]                bit_idx;
        logic [7:0]                step_cnt;
        logic                      busy_n;
        logic                      push;
        logic                      overrun;
        logic [RES_BITS-1:0]       dout;
        logic                      drive;
    } state_s;

    state_s st_reg;
    state_s st_next;
    logic   fifo_ready;

    function automatic logic [RES_BITS-1:0] bit_mask(input logic [3:0] idx);
        bit_mask = RES_BITS'(1) << idx;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic conv_fall;
        logic pd_fall;
        conv_fall = 1'b0;
        pd_fall   = 1'b0;
        st_next   = st_reg;
        st_next.meta.cs_n            = cs_n;
        st_next.meta.rd_n            = rd_n;
        st_next.meta.convert_start_n = convert_start_n;
        st_next.meta.power_down_n    = power_down_n;
        st_next.sync      = st_reg.meta;
        st_next.push      = 1'b0;
        // A result offered while the buffer is full is lost to the stream
        if (st_reg.push && !fifo_ready) begin
            st_next.overrun = 1'b1;
        end
        // Edge detect on synchronized strobe; ignored without chip select
        st_next.conv_prev = st_reg.sync.convert_start_n;
        conv_fall = st_reg.conv_prev && !st_reg.sync.convert_start_n
                    && !st_reg.sync.cs_n;
        st_next.pd_prev = st_reg.sync.power_down_n;
        pd_fall = st_reg.pd_prev && !st_reg.sync.power_down_n;
        if (pd_fall) begin
            st_next.pmode = st_reg.sync.cs_n ? sar_ctrl_pkg::PWR_SLEEP
                                             : sar_ctrl_pkg::PWR_NAP;
        end else if (st_reg.sync.power_down_n) begin
            st_next.pmode = sar_ctrl_pkg::PWR_ON;
        end
        // Output drive: read and chip select both low
        st_next.drive = !st_reg.sync.rd_n && !st_reg.sync.cs_n;
        st_next.dout  = st_reg.latch;
        case (st_reg.state)
            sar_ctrl_pkg::ST_ACQUIRE: begin
                if (conv_fall && st_reg.pmode == sar_ctrl_pkg::PWR_ON) begin
                    st_next.state           = sar_ctrl_pkg::ST_CONVERT;
                    st_next.approx_register = bit_mask(sar_ctrl_pkg::BIT_MSB);
                    st_next.bit_idx         = sar_ctrl_pkg::BIT_MSB;
                    st_next.step_cnt        = '0;
                    st_next.busy_n          = 1'b0;
                end
            end
            sar_ctrl_pkg::ST_CONVERT: begin
                // Further start edges ignored here
                if (st_reg.step_cnt == sar_ctrl_pkg::STEP_LAST) begin
                    st_next.step_cnt = '0;
                    if (!comp_high) begin
                        st_next.approx_register = st_reg.approx_register
                                                  & ~bit_mask(st_reg.bit_idx);
                    end
                    if (st_reg.bit_idx == 4'h0) begin
                        st_next.state = sar_ctrl_pkg::ST_LOAD;
                    end else begin
                        st_next.bit_idx = st_reg.bit_idx - 4'h1;
                        st_next.approx_register = (comp_high ? st_reg.approx_register
                            : st_reg.approx_register & ~bit_mask(st_reg.bit_idx))
                            | bit_mask(st_reg.bit_idx - 4'h1);
                    end
                end else begin
                    st_next.step_cnt = st_reg.step_cnt + 8'h01;
                end
            end
            sar_ctrl_pkg::ST_LOAD: begin
                // Offset binary trial word to two's complement result
                st_next.latch  = st_reg.approx_register
                                 ^ bit_mask(sar_ctrl_pkg::BIT_MSB);
                st_next.busy_n = 1'b1;
                st_next.state  = sar_ctrl_pkg::ST_ACQUIRE;
                st_next.push   = 1'b1;
            end
            default: begin
                st_next.state  = sar_ctrl_pkg::ST_ACQUIRE;
                st_next.busy_n = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg.meta            <= '1;
            st_reg.sync            <= '1;
            st_reg.conv_prev       <= 1'b1;
            st_reg.pd_prev         <= 1'b1;
            st_reg.state           <= sar_ctrl_pkg::ST_ACQUIRE;
            st_reg.pmode           <= sar_ctrl_pkg::PWR_ON;
            st_reg.approx_register <= sar_ctrl_pkg::RESULT_RST;
            st_reg.latch           <= sar_ctrl_pkg::RESULT_RST;
            st_reg.bit_idx         <= '0;
            st_reg.step_cnt        <= '0;
            st_reg.busy_n          <= 1'b1;
            st_reg.push            <= 1'b0;
            st_reg.overrun         <= 1'b0;
            st_reg.dout            <= sar_ctrl_pkg::RESULT_RST;
            st_reg.drive           <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Result stream buffer
    // ------------------------------------------------------------------
    sar_fifo #(
        .WIDTH (RES_BITS),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (st_reg.latch),
        .in_valid  (st_reg.push),
        .in_ready  (fifo_ready),
        .out_data  (stream_data),
        .out_valid (stream_valid),
        .out_ready (stream_ready)
    );

    assign sample_hold = (st_reg.state != sar_ctrl_pkg::ST_ACQUIRE);
    assign dac_code    = st_reg.approx_register;
    assign busy_n      = st_reg.busy_n;
    assign result_out  = st_reg.dout;
    assign result_oe   = {RES_BITS{st_reg.drive}};
    assign nap         = (st_reg.pmode == sar_ctrl_pkg::PWR_NAP);
    assign sleep       = (st_reg.pmode == sar_ctrl_pkg::PWR_SLEEP);
    assign overrun     = st_reg.overrun;
endmodule
`default_nettype wire

//--- src/sar_ctrl_pkg.sv
// Package: constants and carrier types for the converter control block
// Overview of operation
// - A falling power-down input enters nap when chip select is low, sleep when it is high.
// - Convert-start and read strobes are ignored unless chip select is low.
// - Result outputs are driven only while read and chip select are both low.
// - A conversion begins on the falling edge of convert-start.
// - Busy stays low for the whole conversion.
// - A new valid result reaches the result outputs one clock after busy rises, and the host may capture it then.
// - Each result is one 14-bit word on a parallel three-state bus.
// - The approximation register is loaded with only its most significant bit set at the start of each conversion.
// - Convert-start edges during a running conversion are ignored.
// - The 14 bits are resolved one per step from the most significant bit down.
// - At the end of conversion the approximation register is copied to the output latch with its most significant bit inverted.
// - Conversion steps are timed from an internal clock.
// - The result is two's complement binary.
package sar_ctrl_pkg;

    localparam int RES_BITS = 14;
    localparam int CLK_HZ = 20_000_000;
    localparam int STEP_NS = 100;
    localparam int STEP_CYCLES = (STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ACQ_NS = 400;
    localparam int ACQ_CYCLES = (ACQ_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int FIFO_DEPTH = 16;

    localparam logic [RES_BITS-1:0] RESULT_RST = 14'h0000;
    localparam logic [3:0]          BIT_MSB = 4'hd;
    localparam logic [7:0]          STEP_LAST = 8'(STEP_CYCLES - 1);

    typedef enum logic [1:0] {
        ST_ACQUIRE = 2'h0,
        ST_CONVERT = 2'h1,
        ST_LOAD    = 2'h3
    } conv_state_e;

    typedef enum logic [1:0] {
        PWR_ON    = 2'h0,
        PWR_NAP   = 2'h1,
        PWR_SLEEP = 2'h2
    } power_mode_e;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic convert_start_n;
        logic power_down_n;
    } pins_s;

endpackage

//--- src/sar_fifo.sv
// Synchronous valid/ready FIFO
`timescale 1ns/1ps
`default_nettype none
module sar_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
        if (rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= AW'((wr_reg == AW'(DEPTH - 1)) ? 0 : wr_reg + 1'b1);
            end
            if (pop) begin
                rd_reg <= AW'((rd_reg == AW'(DEPTH - 1)) ? 0 : rd_reg + 1'b1);
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

//--- verif/sar_ctrl_monitor.sv
// Assertion checker on the converter control ports
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_monitor #(
    parameter int RES_BITS = 14
) (
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                sample_hold,
    input wire logic                cs_n,
    input wire logic                rd_n,
    input wire logic                power_down_n,
    input wire logic                busy_n,
    input wire logic [RES_BITS-1:0] dac_code,
    input wire logic [RES_BITS-1:0] result_oe,
    input wire logic                nap,
    input wire logic                sleep,
    input wire logic                stream_valid,
    input wire logic                overrun
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_oe_on; (!cs_n && !rd_n)[*5] |-> &result_oe; endproperty
    property p_oe_off; (cs_n || rd_n)[*5] |-> result_oe == '0; endproperty
    property p_busy_min; $fell(busy_n) |-> !busy_n[*8]; endproperty
    property p_busy_max; $fell(busy_n) |-> ##[25:35] busy_n; endproperty
    property p_clear; $fell(busy_n) |-> dac_code == {1'b1, {(RES_BITS-1){1'b0}}}; endproperty
    property p_no_cs; cs_n[*5] ##0 busy_n |=> busy_n; endproperty
    property p_nap; $fell(power_down_n) && !cs_n |-> ##[2:5] (nap && !sleep); endproperty
    property p_sleep; $fell(power_down_n) && cs_n |-> ##[2:5] (sleep && !nap); endproperty
    property p_down_block; (nap || sleep) && busy_n |=> busy_n; endproperty
    property p_push; $rose(busy_n) |-> ##[1:2] stream_valid; endproperty
    property p_hold; sample_hold == !busy_n; endproperty
    a_oe_on: assert property (p_oe_on) else $error("outputs not enabled");
    a_oe_off: assert property (p_oe_off) else $error("outputs not floated");
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    a_busy_max: assert property (p_busy_max) else $error("busy length");
    a_clear: assert property (p_clear) else $error("approx start word");
    a_no_cs: assert property (p_no_cs) else $error("start without select");
    a_nap: assert property (p_nap) else $error("nap not entered");
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
    a_down_block: assert property (p_down_block) else $error("start in shutdown");
    a_push: assert property (p_push) else $error("result not offered");
    a_hold: assert property (p_hold) else $error("hold differs from busy");
    c_conv: cover property ($rose(busy_n));
    c_nap: cover property ($rose(nap));
    c_sleep: cover property ($rose(sleep));
    c_over: cover property ($rose(overrun));
endmodule
`default_nettype wire

//--- verif/sar_comp_model.sv
// Comparator model holding the sampled input as a two's complement code
`timescale 1ns/1ps
`default_nettype none
module sar_comp_model (
    input wire logic [13:0] dac_code,
    input wire logic [13:0] sample,
    output logic            comp_high
);
    // Trial word is offset binary; the held sample is two's complement
    assign comp_high = (dac_code <= {~sample[13], sample[12:0]});
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, rst, cs_n, rd_n, convert_start_n, power_down_n, comp_high;
    logic        busy_n, sample_hold, nap, sleep, stream_valid, stream_ready, overrun;
    logic [13:0] dac_code, result_out, result_oe, stream_data, target;
    logic [13:0] q[$];
    integer      seed;
    int          n_errors, tests_run, i;
    sar_adc_parallel_control i_sar_adc_parallel_control (.clk(clk), .rst(rst), .cs_n(cs_n),
        .rd_n(rd_n), .convert_start_n(convert_start_n), .power_down_n(power_down_n),
        .comp_high(comp_high), .sample_hold(sample_hold), .dac_code(dac_code),
        .busy_n(busy_n), .result_out(result_out), .result_oe(result_oe), .nap(nap),
        .sleep(sleep), .stream_data(stream_data), .stream_valid(stream_valid),
        .stream_ready(stream_ready), .overrun(overrun));
    sar_comp_model i_sar_comp_model (.dac_code(dac_code), .sample(target),
        .comp_high(comp_high));
    always #25 clk = ~clk;
    task results;
        $display("errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wbusy(input logic lvl);
        for (int k = 0; k < 80 && busy_n !== lvl; k++) begin
            @(posedge clk);
            #1;
        end
        check("busy_wait", busy_n, lvl);
        if (busy_n !== lvl) results();
    endtask
    task pulse;
        @(posedge clk) convert_start_n <= 1'b0;
        repeat (3) @(posedge clk);
        convert_start_n <= 1'b1;
    endtask
    task conv(input bit push, input bit retrig);
        repeat (10) @(posedge clk);
        target <= 14'($random(seed));
        pulse;
        wbusy(1'b0);
        if (retrig) pulse;
        wbusy(1'b1);
        if (push) q.push_back(target);
        repeat (2) @(posedge clk);
        #1 check("result_out", result_out, target);
    endtask
    always @(posedge clk) begin
        if (!rst && stream_valid === 1'b1 && stream_ready === 1'b1) begin
            if (q.size() == 0)
                check("stream_extra", 1, 0);
            else
                check("stream_data", stream_data, q.pop_front());
        end
    end
    initial begin
        clk = 0; rst = 1; cs_n = 0; rd_n = 1; convert_start_n = 1; power_down_n = 1;
        stream_ready = 1; target = '0; seed = 32'h4bf0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 check("busy_reset", busy_n, 1);
        check("oe_reset", |result_oe, 0);
        for (i = 0; i < 6; i++) conv(1, i == 2);
        @(posedge clk) rd_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1 check("read_oe", &result_oe, 1);
        check("read_data", result_out, target);
        @(posedge clk) cs_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1 check("read_float", |result_oe, 0);
        pulse;
        repeat (20) @(posedge clk);
        #1 check("start_unselected", busy_n, 1);
        @(posedge clk) rd_n <= 1'b1;
        power_down_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1 check("sleep", {nap, sleep}, 2'b01);
        @(posedge clk) cs_n <= 1'b0;
        pulse;
        repeat (20) @(posedge clk);
        #1 check("start_shutdown", busy_n, 1);
        @(posedge clk) power_down_n <= 1'b1;
        repeat (10) @(posedge clk);
        power_down_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1 check("nap", {nap, sleep}, 2'b10);
        @(posedge clk) power_down_n <= 1'b1;
        repeat (10) @(posedge clk);
        #1 check("wake", {nap, sleep}, 2'b00);
        conv(1, 0);
        @(posedge clk) stream_ready <= 1'b0;
        for (i = 0; i < 16; i++) conv(1, 0);
        check("no_overrun", overrun, 0);
        conv(0, 0);
        check("overrun", overrun, 1);
        @(posedge clk) stream_ready <= 1'b1;
        for (i = 0; i < 100 && q.size() != 0; i++) @(posedge clk);
        check("drained", q.size(), 0);
        results();
    end
endmodule
bind sar_adc_parallel_control sar_ctrl_monitor #(.RES_BITS(RES_BITS)) i_sar_ctrl_monitor (
    .clk(clk), .rst(rst), .sample_hold(sample_hold), .cs_n(cs_n), .rd_n(rd_n),
    .power_down_n(power_down_n),
    .busy_n(busy_n), .dac_code(dac_code), .result_oe(result_oe), .nap(nap), .sleep(sleep),
    .stream_valid(stream_valid), .overrun(overrun));
`default_nettype wire
